// ===== verilog/cpurf_top.v
// processor register file: general registers, pairing, program counter and address registers
`timescale 1ns/100ps
`include "cpurf_regs.vh"

module cpurf_top #(
  parameter PC_RESET_VALUE = `CPURF_PC_RST,
  parameter STEP_W         = `CPURF_STEP_W
) (
  // clock and reset
  input  wire                     clk,
  input  wire                     rst_n,
  input  wire                     warmReset,
  // operand read port a
  input  wire [`CPURF_SEL_W-1:0]  rdSelA,
  input  wire [1:0]               rdSizeA,
  output wire [`CPURF_WIDE_W-1:0] rdDataA,
  // operand read port b
  input  wire [`CPURF_SEL_W-1:0]  rdSelB,
  input  wire [1:0]               rdSizeB,
  output wire [`CPURF_WIDE_W-1:0] rdDataB,
  // result write port
  input  wire                     wrEn,
  input  wire [`CPURF_SEL_W-1:0]  wrSel,
  input  wire [1:0]               wrSize,
  input  wire [`CPURF_WIDE_W-1:0] wrData,
  // program counter
  input  wire                     pcWrEn,
  input  wire [`CPURF_PC_W-1:0]   pcWrData,
  input  wire                     pcAdvance,
  input  wire [STEP_W-1:0]        pcStep,
  output reg  [`CPURF_PC_W-1:0]   programCounter,
  // interrupt stack pointer
  input  wire                     intStackWrEn,
  input  wire [`CPURF_WIDE_W-1:0] intStackWrData,
  input  wire                     intStackPush,
  input  wire                     intStackPop,
  input  wire [STEP_W-1:0]        intStackStep,
  output wire [`CPURF_WIDE_W-1:0] interruptStackPointer,
  // user stack pointer
  input  wire                     userStackWrEn,
  input  wire [`CPURF_WIDE_W-1:0] userStackWrData,
  output reg  [`CPURF_WIDE_W-1:0] userStackPointer,
  // status word and configuration
  input  wire                     statusWrEn,
  input  wire [`CPURF_GPR_W-1:0]  statusWrData,
  output reg  [`CPURF_GPR_W-1:0]  processorStatusWord,
  input  wire                     cfgWrEn,
  input  wire [`CPURF_GPR_W-1:0]  cfgWrData,
  output reg  [`CPURF_GPR_W-1:0]  configWord
);

  // ****************************************************************
  // pair and width decode
  // ****************************************************************

  // returns {upper slot, lower slot} of a named register for an operand size
  function [2*`CPURF_HW_AW-1:0] pairMap;
    input [`CPURF_SEL_W-1:0] sel;
    input [1:0]              size;
    input                    legacy;
    reg   [`CPURF_HW_AW-1:0] lo;
    reg   [`CPURF_HW_AW-1:0] hi;
    begin
      lo = {1'b0, sel};
      hi = lo;
      if (size == `CPURF_SZ_DBL) begin
        if (sel <= `CPURF_IDX_R11) begin
          hi = lo + `CPURF_HW_NEXT;
        end else if (legacy && (sel != `CPURF_IDX_STK)) begin
          if (sel == `CPURF_IDX_RET) begin
            lo = `CPURF_HW_R13;
          end
          hi = lo + `CPURF_HW_NEXT;
        end else begin
          hi = lo + `CPURF_HW_HI_OFS;
        end
      end
      pairMap = {hi, lo};
    end
  endfunction

  // byte lanes of the lower slot that an operand size references
  function [1:0] laneMask;
    input [1:0] size;
    begin
      if (size == `CPURF_SZ_BYTE) begin
        laneMask = `CPURF_MASK_BYTE;
      end else begin
        laneMask = `CPURF_MASK_WORD;
      end
    end
  endfunction

  wire                        legacyPairingSelectBit;
  wire [2*`CPURF_HW_AW-1:0]   mapA;
  wire [2*`CPURF_HW_AW-1:0]   mapB;
  wire [2*`CPURF_HW_AW-1:0]   mapW;
  wire                        wrGo;
  wire                        warmGo;
  wire [1:0]                  wrBe;
  wire                        wrHiEn;
  wire [`CPURF_WIDE_W-1:0]    warmData;

  assign legacyPairingSelectBit = configWord[`CPURF_LEGACY_BIT];

  assign mapA = pairMap(rdSelA, rdSizeA, legacyPairingSelectBit);
  assign mapB = pairMap(rdSelB, rdSizeB, legacyPairingSelectBit);
  assign mapW = pairMap(wrSel, wrSize, legacyPairingSelectBit);

  assign wrGo   = rst_n & wrEn;
  assign warmGo = rst_n & warmReset;
  assign wrBe   = wrGo ? laneMask(wrSize) : 2'h0;
  assign wrHiEn = wrGo & (wrSize == `CPURF_SZ_DBL);

  // old counter split over the (R1,R0) pair, upper slot padded
  assign warmData = {`CPURF_PC_HI_PAD, programCounter};

  // ****************************************************************
  // general-purpose register storage
  // ****************************************************************
  cpurf_gpr_mem #(
    .AW    (`CPURF_HW_AW),
    .DEPTH (`CPURF_HW_DEPTH),
    .DW    (`CPURF_GPR_W)
  ) uGprMem (
    .clk       (clk),
    .rst_n     (rst_n),
    .rd0LoAddr (mapA[`CPURF_HW_AW-1:0]),
    .rd0HiAddr (mapA[2*`CPURF_HW_AW-1:`CPURF_HW_AW]),
    .rd0LoMask (laneMask(rdSizeA)),
    .rd0HiEn   (rdSizeA == `CPURF_SZ_DBL),
    .rd0Data   (rdDataA),
    .rd1LoAddr (mapB[`CPURF_HW_AW-1:0]),
    .rd1HiAddr (mapB[2*`CPURF_HW_AW-1:`CPURF_HW_AW]),
    .rd1LoMask (laneMask(rdSizeB)),
    .rd1HiEn   (rdSizeB == `CPURF_SZ_DBL),
    .rd1Data   (rdDataB),
    .wr0LoAddr (mapW[`CPURF_HW_AW-1:0]),
    .wr0HiAddr (mapW[2*`CPURF_HW_AW-1:`CPURF_HW_AW]),
    .wr0LoBe   (wrBe),
    .wr0HiEn   (wrHiEn),
    .wr0Data   (wrData),
    .wr1LoAddr (`CPURF_HW_R0),
    .wr1HiAddr (`CPURF_HW_R1),
    .wr1LoBe   (warmGo ? `CPURF_MASK_WORD : 2'h0),
    .wr1HiEn   (warmGo),
    .wr1Data   (warmData)
  );

  // ****************************************************************
  // interrupt stack pointer
  // ****************************************************************
  cpurf_int_stack #(
    .SW (STEP_W)
  ) uIntStack (
    .clk       (clk),
    .rst_n     (rst_n),
    .wrEn      (intStackWrEn),
    .wrData    (intStackWrData),
    .pushEn    (intStackPush),
    .popEn     (intStackPop),
    .stepBytes (intStackStep),
    .stackPtr  (interruptStackPointer)
  );

  // ****************************************************************
  // program counter
  // ****************************************************************
  reg [`CPURF_PC_W-1:0] next_programCounter;

  always @* begin
    next_programCounter = programCounter;
    if (warmReset) begin
      next_programCounter = PC_RESET_VALUE;
    end else if (pcWrEn) begin
      next_programCounter = pcWrData;
    end else if (pcAdvance) begin
      next_programCounter = programCounter + {{(`CPURF_PC_W-STEP_W){1'b0}}, pcStep};
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      programCounter <= PC_RESET_VALUE & `CPURF_PC_KEEP;
    end else begin
      programCounter <= next_programCounter & `CPURF_PC_KEEP;
    end
  end

  // ****************************************************************
  // user stack pointer, status word, configuration
  // ****************************************************************
  reg [`CPURF_WIDE_W-1:0] next_userStackPointer;
  reg [`CPURF_GPR_W-1:0]  next_processorStatusWord;
  reg [`CPURF_GPR_W-1:0]  next_configWord;

  // reserved bits are stored as written; software keeps them zero
  always @* begin
    next_userStackPointer    = userStackPointer;
    next_processorStatusWord = processorStatusWord;
    next_configWord          = configWord;
    if (userStackWrEn) begin
      next_userStackPointer = userStackWrData;
    end
    if (statusWrEn) begin
      next_processorStatusWord = statusWrData;
    end
    if (cfgWrEn) begin
      next_configWord = cfgWrData;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      userStackPointer    <= `CPURF_USTK_RST;
      processorStatusWord <= `CPURF_STAT_RST;
      configWord          <= `CPURF_CFG_RST;
    end else begin
      userStackPointer    <= next_userStackPointer;
      processorStatusWord <= next_processorStatusWord;
      configWord          <= next_configWord;
    end
  end

endmodule // cpurf_top

// ===== include/cpurf_regs.vh
// constants shared by the processor register file and its storage modules
`ifndef CPURF_REGS_VH
`define CPURF_REGS_VH

// ****************************************************************
// widths
// ****************************************************************
`define CPURF_SEL_W       4
`define CPURF_HW_AW       5
`define CPURF_HW_DEPTH    20
`define CPURF_GPR_W       16
`define CPURF_WIDE_W      32
`define CPURF_PC_W        24
`define CPURF_STEP_W      6

// ****************************************************************
// register numbers as named by the execution logic
// ****************************************************************
`define CPURF_IDX_R11     4'hB
`define CPURF_IDX_RET     4'hE
`define CPURF_IDX_STK     4'hF

// ****************************************************************
// halfword storage slots: 0..15 low halves, 16..19 upper halves
// ****************************************************************
`define CPURF_HW_R0       5'h00
`define CPURF_HW_R1       5'h01
`define CPURF_HW_R13      5'h0D
`define CPURF_HW_NEXT     5'h01
`define CPURF_HW_HI_OFS   5'h04

// ****************************************************************
// operand sizes and byte lane masks
// ****************************************************************
`define CPURF_SZ_BYTE     2'h0
`define CPURF_SZ_WORD     2'h1
`define CPURF_SZ_DBL      2'h2
`define CPURF_MASK_BYTE   2'h1
`define CPURF_MASK_WORD   2'h3

// ****************************************************************
// field positions and forced-zero masks
// ****************************************************************
`define CPURF_LEGACY_BIT  2
`define CPURF_PC_KEEP     24'hFFFFFE
`define CPURF_ISTK_KEEP   32'h00FFFFFE
`define CPURF_PC_HI_PAD   8'h00

// ****************************************************************
// reset values
// ****************************************************************
`define CPURF_PC_RST      24'h000000
`define CPURF_ISTK_RST    32'h00000000
`define CPURF_USTK_RST    32'h00000000
`define CPURF_STAT_RST    16'h0000
`define CPURF_CFG_RST     16'h0000
`define CPURF_RD_RST      32'h00000000

`endif

// ===== verilog/cpurf_gpr_mem.v
// halfword storage of the general-purpose registers with registered read ports
`timescale 1ns/100ps
`include "cpurf_regs.vh"

module cpurf_gpr_mem #(
  parameter AW    = `CPURF_HW_AW,
  parameter DEPTH = `CPURF_HW_DEPTH,
  parameter DW    = `CPURF_GPR_W
) (
  // clock and reset
  input  wire            clk,
  input  wire            rst_n,
  // read port 0
  input  wire [AW-1:0]   rd0LoAddr,
  input  wire [AW-1:0]   rd0HiAddr,
  input  wire [1:0]      rd0LoMask,
  input  wire            rd0HiEn,
  output reg  [2*DW-1:0] rd0Data,
  // read port 1
  input  wire [AW-1:0]   rd1LoAddr,
  input  wire [AW-1:0]   rd1HiAddr,
  input  wire [1:0]      rd1LoMask,
  input  wire            rd1HiEn,
  output reg  [2*DW-1:0] rd1Data,
  // write port 0
  input  wire [AW-1:0]   wr0LoAddr,
  input  wire [AW-1:0]   wr0HiAddr,
  input  wire [1:0]      wr0LoBe,
  input  wire            wr0HiEn,
  input  wire [2*DW-1:0] wr0Data,
  // write port 1, wins over port 0
  input  wire [AW-1:0]   wr1LoAddr,
  input  wire [AW-1:0]   wr1HiAddr,
  input  wire [1:0]      wr1LoBe,
  input  wire            wr1HiEn,
  input  wire [2*DW-1:0] wr1Data
);

  reg [DW-1:0] mem [0:DEPTH-1];

  // ****************************************************************
  // writes: byte lanes on the low half, whole upper half
  // ****************************************************************
  always @(posedge clk) begin
    if (wr0LoBe[0]) mem[wr0LoAddr][DW/2-1:0] <= wr0Data[DW/2-1:0];
    if (wr0LoBe[1]) mem[wr0LoAddr][DW-1:DW/2] <= wr0Data[DW-1:DW/2];
    if (wr0HiEn) mem[wr0HiAddr] <= wr0Data[2*DW-1:DW];
    if (wr1LoBe[0]) mem[wr1LoAddr][DW/2-1:0] <= wr1Data[DW/2-1:0];
    if (wr1LoBe[1]) mem[wr1LoAddr][DW-1:DW/2] <= wr1Data[DW-1:DW/2];
    if (wr1HiEn) mem[wr1HiAddr] <= wr1Data[2*DW-1:DW];
  end

  // ****************************************************************
  // reads: lanes not referenced return zero, old data on collision
  // ****************************************************************
  always @(posedge clk) begin
    if (!rst_n) begin
      rd0Data <= `CPURF_RD_RST;
      rd1Data <= `CPURF_RD_RST;
    end else begin
      rd0Data <= {(rd0HiEn ? mem[rd0HiAddr] : {DW{1'b0}}),
                  mem[rd0LoAddr] & {{(DW/2){rd0LoMask[1]}}, {(DW/2){rd0LoMask[0]}}}};
      rd1Data <= {(rd1HiEn ? mem[rd1HiAddr] : {DW{1'b0}}),
                  mem[rd1LoAddr] & {{(DW/2){rd1LoMask[1]}}, {(DW/2){rd1LoMask[0]}}}};
    end
  end

endmodule // cpurf_gpr_mem

// ===== verilog/cpurf_isp.v
// interrupt stack pointer with push, pop and software load
`timescale 1ns/100ps
`include "cpurf_regs.vh"

module cpurf_int_stack #(
  parameter SW = `CPURF_STEP_W
) (
  // clock and reset
  input  wire                     clk,
  input  wire                     rst_n,
  // software load
  input  wire                     wrEn,
  input  wire [`CPURF_WIDE_W-1:0] wrData,
  // exception entry and return
  input  wire                     pushEn,
  input  wire                     popEn,
  input  wire [SW-1:0]            stepBytes,
  // current value
  output reg  [`CPURF_WIDE_W-1:0] stackPtr
);

  reg  [`CPURF_WIDE_W-1:0] next_stackPtr;
  wire [`CPURF_WIDE_W-1:0] step;

  assign step = {{(`CPURF_WIDE_W-SW){1'b0}}, stepBytes};

  always @* begin
    next_stackPtr = stackPtr;
    if (wrEn) begin
      next_stackPtr = wrData;
    end else if (pushEn) begin
      next_stackPtr = stackPtr - step;
    end else if (popEn) begin
      next_stackPtr = stackPtr + step;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      stackPtr <= `CPURF_ISTK_RST;
    end else begin
      stackPtr <= next_stackPtr & `CPURF_ISTK_KEEP;
    end
  end

endmodule // cpurf_int_stack

// ===== bench/cpurf_top_asserts.sv
// concurrent checks on the processor register file ports
`timescale 1ns/100ps
`include "cpurf_regs.vh"

module cpurf_top_asserts #(
  parameter PC_RESET_VALUE = `CPURF_PC_RST,
  parameter STEP_W         = `CPURF_STEP_W
) (
  // clock and reset
  input wire                     clk,
  input wire                     rst_n,
  input wire                     warmReset,
  // operand reads
  input wire [3:0]               rdSelA,
  input wire [1:0]               rdSizeA,
  input wire [31:0]              rdDataA,
  input wire [3:0]               rdSelB,
  input wire [1:0]               rdSizeB,
  input wire [31:0]              rdDataB,
  // program counter
  input wire                     pcWrEn,
  input wire                     pcAdvance,
  input wire [STEP_W-1:0]        pcStep,
  input wire [23:0]              programCounter,
  // interrupt stack pointer and configuration
  input wire                     intStackWrEn,
  input wire [31:0]              intStackWrData,
  input wire                     intStackPush,
  input wire [STEP_W-1:0]        intStackStep,
  input wire [31:0]              interruptStackPointer,
  input wire [15:0]              configWord
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_PC_EVEN: assert property (programCounter[0] == 1'b0)
    else $error("program counter bit zero set");
  AST_ISTK_ZERO: assert property (
    interruptStackPointer[31:24] == 8'h00 && !interruptStackPointer[0])
    else $error("interrupt stack pointer forced bits set");
  AST_PC_RESET: assert property (disable iff (1'b0)
    !rst_n |=> programCounter == (PC_RESET_VALUE & `CPURF_PC_KEEP))
    else $error("program counter not at start value after reset");
  AST_PC_WARM: assert property (
    warmReset |=> programCounter == (PC_RESET_VALUE & `CPURF_PC_KEEP))
    else $error("program counter not reloaded on warm reset");
  AST_WARM_SAVE: assert property (
    (warmReset ##1 (rdSelA == 4'h0 && rdSizeA == `CPURF_SZ_DBL))
    |=> rdDataA == {8'h00, $past(programCounter, 2)})
    else $error("old program counter not in pair one-zero");
  AST_PC_STEP: assert property (
    !warmReset && !pcWrEn && pcAdvance
    |=> programCounter == (($past(programCounter) + 24'(pcStep)) & `CPURF_PC_KEEP))
    else $error("program counter advance wrong");
  AST_ISTK_PUSH: assert property (
    intStackPush && !intStackWrEn |=> interruptStackPointer ==
    (($past(interruptStackPointer) - 32'(intStackStep)) & `CPURF_ISTK_KEEP))
    else $error("interrupt stack push did not decrement");
  AST_ISTK_LOAD: assert property (
    intStackWrEn |=> interruptStackPointer == ($past(intStackWrData) & `CPURF_ISTK_KEEP))
    else $error("interrupt stack pointer load wrong");
  AST_BYTE_READ: assert property (rdSizeA == `CPURF_SZ_BYTE |=> rdDataA[31:8] == 24'h0)
    else $error("byte read shows upper bits");
  AST_ALIAS: assert property (
    configWord[`CPURF_LEGACY_BIT] && rdSelA == 4'hD && rdSelB == 4'hE
    && rdSizeA == `CPURF_SZ_DBL && rdSizeB == `CPURF_SZ_DBL |=> rdDataA == rdDataB)
    else $error("legacy pair alias differs");

  // ****************************************************************
  // coverage
  // ****************************************************************
  CV_WARM: cover property (warmReset);
  CV_PUSH: cover property (intStackPush);
  CV_ALIAS: cover property (configWord[2] && rdSelA == 4'hD && rdSelB == 4'hE);
endmodule // cpurf_top_asserts

bind cpurf_top cpurf_top_asserts #(.PC_RESET_VALUE(PC_RESET_VALUE), .STEP_W(STEP_W)) uChk (
  .clk(clk), .rst_n(rst_n), .warmReset(warmReset), .rdSelA(rdSelA), .rdSizeA(rdSizeA),
  .rdDataA(rdDataA), .rdSelB(rdSelB), .rdSizeB(rdSizeB), .rdDataB(rdDataB), .pcWrEn(pcWrEn),
  .pcAdvance(pcAdvance), .pcStep(pcStep), .programCounter(programCounter),
  .intStackWrEn(intStackWrEn), .intStackWrData(intStackWrData), .intStackPush(intStackPush),
  .intStackStep(intStackStep), .interruptStackPointer(interruptStackPointer),
  .configWord(configWord));

// ===== bench/cpurf_exec_model.sv
// execution logic model driving the operand and result ports
`timescale 1ns/100ps

module cpurf_exec_model (
  // clock
  input  wire        clk,
  // result write
  output logic       wrEn,
  output logic [3:0] wrSel,
  output logic [1:0] wrSize,
  output logic [31:0] wrData,
  // operand reads
  output logic [3:0] rdSelA,
  output logic [1:0] rdSizeA,
  output logic [3:0] rdSelB,
  output logic [1:0] rdSizeB
);
  initial begin
    {wrEn, wrSel, wrSize, wrData, rdSelA, rdSizeA, rdSelB, rdSizeB} = '0;
  end

  // one cycle holding a write and two reads, then the write is withdrawn
  task automatic op(input logic w, input logic [3:0] ws, input logic [1:0] wz,
                    input logic [31:0] wd, input logic [3:0] sa, input logic [1:0] za,
                    input logic [3:0] sb, input logic [1:0] zb);
    @(negedge clk);
    {wrEn, wrSel, wrSize, wrData} = {w, ws, wz, wd};
    {rdSelA, rdSizeA, rdSelB, rdSizeB} = {sa, za, sb, zb};
    @(negedge clk);
    wrEn = 1'b0;
    wrData = ~wrData;
  endtask
endmodule // cpurf_exec_model

// ===== bench/cpu_register_file_and_address_regs_bench.sv
// self-checking bench of the processor register file
`timescale 1ns/100ps

module cpu_register_file_and_address_regs_bench;
  logic        clk, rst_n, warmReset, wrEn, pcWrEn, pcAdvance, lg;
  logic        intStackWrEn, intStackPush, intStackPop, userStackWrEn, statusWrEn, cfgWrEn;
  logic [3:0]  wrSel, rdSelA, rdSelB;
  logic [1:0]  wrSize, rdSizeA, rdSizeB;
  logic [5:0]  pcStep, intStackStep;
  logic [15:0] statusWrData, cfgWrData, processorStatusWord, configWord;
  logic [23:0] pcWrData, programCounter;
  logic [31:0] wrData, rdDataA, rdDataB, intStackWrData, userStackWrData;
  logic [31:0] interruptStackPointer, userStackPointer, pc, istk, r, ea, eb;
  logic [15:0] s [20];
  int          n_mismatch, tests_run, k, lo, hi;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  cpurf_exec_model uExec (.clk(clk), .wrEn(wrEn), .wrSel(wrSel), .wrSize(wrSize),
    .wrData(wrData), .rdSelA(rdSelA), .rdSizeA(rdSizeA), .rdSelB(rdSelB), .rdSizeB(rdSizeB));

  cpurf_top DUT (.clk(clk), .rst_n(rst_n), .warmReset(warmReset), .rdSelA(rdSelA),
    .rdSizeA(rdSizeA), .rdDataA(rdDataA), .rdSelB(rdSelB), .rdSizeB(rdSizeB), .rdDataB(rdDataB),
    .wrEn(wrEn), .wrSel(wrSel), .wrSize(wrSize), .wrData(wrData), .pcWrEn(pcWrEn),
    .pcWrData(pcWrData), .pcAdvance(pcAdvance), .pcStep(pcStep), .programCounter(programCounter),
    .intStackWrEn(intStackWrEn), .intStackWrData(intStackWrData), .intStackPush(intStackPush),
    .intStackPop(intStackPop), .intStackStep(intStackStep),
    .interruptStackPointer(interruptStackPointer), .userStackWrEn(userStackWrEn),
    .userStackWrData(userStackWrData), .userStackPointer(userStackPointer),
    .statusWrEn(statusWrEn), .statusWrData(statusWrData),
    .processorStatusWord(processorStatusWord), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData),
    .configWord(configWord));

  // ****************************************************************
  // reference model and checks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // halfword slots 0..15 low halves, 16..19 upper halves of 12..15
  function automatic void slots(input logic [3:0] sel, input logic [1:0] sz);
    if (sz != 2'h2 || sel <= 4'hB) begin
      lo = sel;
      hi = sel + 1;
    end else if (!lg) begin
      lo = sel;
      hi = sel + 4;
    end else if (sel == 4'hF) begin
      lo = 15;
      hi = 19;
    end else begin
      lo = (sel == 4'hC) ? 12 : 13;
      hi = lo + 1;
    end
  endfunction

  function automatic logic [31:0] rdx(input logic [3:0] sel, input logic [1:0] sz);
    slots(sel, sz);
    case (sz)
      2'h0: return {24'h0, s[lo][7:0]};
      2'h2: return {s[hi], s[lo]};
      default: return {16'h0, s[lo]};
    endcase
  endfunction

  task automatic xop(input logic w, input logic [3:0] ws, input logic [1:0] wz,
                     input logic [31:0] wd, input logic [3:0] sa, input logic [1:0] za,
                     input logic [3:0] sb, input logic [1:0] zb);
    ea = rdx(sa, za);
    eb = rdx(sb, zb);
    uExec.op(w, ws, wz, wd, sa, za, sb, zb);
    if (w) begin
      slots(ws, wz);
      if (wz == 2'h0) s[lo][7:0] = wd[7:0];
      else s[lo] = wd[15:0];
      if (wz == 2'h2) s[hi] = wd[31:16];
    end
    chk(rdDataA, ea);
    chk(rdDataB, eb);
  endtask

  // k selects one control: 0 pc load, 1 advance, 2 warm, 3 isp load, 4 push, 5 pop, 6..8 loads
  task automatic misc(input int k, input logic [31:0] d);
    @(negedge clk);
    {pcWrData, pcStep, intStackStep} = {d[23:0], d[5:0], d[5:0]};
    {intStackWrData, userStackWrData} = {d, d};
    {statusWrData, cfgWrData} = {d[15:0], d[15:0]};
    {pcWrEn, pcAdvance, warmReset, intStackWrEn, intStackPush, intStackPop, userStackWrEn,
      statusWrEn, cfgWrEn} = 9'h100 >> k;
    @(negedge clk);
    {pcWrEn, pcAdvance, warmReset, intStackWrEn, intStackPush, intStackPop, userStackWrEn,
      statusWrEn, cfgWrEn} = 9'h000;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    #20000;
    n_mismatch++;
    finish_test;
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial begin
    {rst_n, lg, n_mismatch, tests_run} = '0;
    void'($urandom(31));
    misc(9, 32'h0);
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    chk({8'h0, programCounter}, 32'h0);
    chk(interruptStackPointer, 32'h0);
    for (k = 0; k < 16; k++)
      xop(1'b1, k[3:0], 2'h2, $urandom, 4'h0, 2'h0, 4'h1, 2'h1);
    for (k = 0; k < 2; k++) begin
      misc(8, {29'h0, k[0], 2'h0});
      lg = k[0];
      chk({16'h0, configWord}, {29'h0, k[0], 2'h0});
      repeat (60) xop(1'b1, 4'($urandom_range(15)), 2'($urandom_range(3)), $urandom,
        4'($urandom_range(15)), 2'($urandom_range(3)), 4'($urandom_range(15)),
        2'($urandom_range(3)));
      xop(1'b0, 4'h0, 2'h0, 32'h0, 4'hD, 2'h2, 4'hE, 2'h2);
    end
    r = $urandom;
    misc(0, r);
    pc = r & 32'h00FFFFFE;
    chk({8'h0, programCounter}, pc);
    // pair one-zero stays selected so the warm save is read right after it
    xop(1'b0, 4'h0, 2'h0, 32'h0, 4'h0, 2'h2, 4'h1, 2'h0);
    misc(2, 32'h0);
    s[0] = pc[15:0];
    s[1] = {8'h00, pc[23:16]};
    pc = 32'h0;
    chk({8'h0, programCounter}, pc);
    xop(1'b0, 4'h0, 2'h0, 32'h0, 4'h0, 2'h2, 4'h1, 2'h0);
    repeat (8) begin
      r = $urandom_range(63);
      misc(1, r);
      pc = (pc + r) & 32'h00FFFFFE;
      chk({8'h0, programCounter}, pc);
    end
    r = $urandom | 32'hFF000001;
    misc(3, r);
    istk = r & 32'h00FFFFFE;
    chk(interruptStackPointer, istk);
    repeat (12) begin
      r = $urandom_range(63);
      k = 4 + $urandom_range(1);
      misc(k, r);
      istk = ((k == 4) ? istk - r : istk + r) & 32'h00FFFFFE;
      chk(interruptStackPointer, istk);
    end
    r = $urandom;
    misc(6, r);
    chk(userStackPointer, r);
    misc(7, r & 32'h00000FFF);
    chk({16'h0, processorStatusWord}, r & 32'h00000FFF);
    finish_test;
  end
endmodule // cpu_register_file_and_address_regs_bench
